// ===== rtl/vdh_host.sv
// host controller that drives a dual-port video dram through its pins
// assumes a software master on a plain strobe port and the dram on the pins
// Behaviour
// - keep special flag two low always
// - both byte strobes high during reads
// - flag one high at row fall selects specials
// - delayed write needs output gate high first
// - read-modify-write drives data after raising gate
`timescale 1ns/1ps
module vdh_host (
    // clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        RST_IN,
    // register port
    input  wire logic [7:0]  ADDR_IN,
    input  wire logic [31:0] WDATA_IN,
    input  wire logic        WR_IN,
    input  wire logic        RD_IN,
    output logic      [31:0] RDATA_OUT,
    // dram port
    output logic             ROW_STROBE_N_OUT,
    output logic             COL_STROBE_N_OUT,
    output logic             UPPER_BYTE_WRITE_STROBE_N_OUT,
    output logic             LOWER_BYTE_WRITE_STROBE_N_OUT,
    output logic             TRANSFER_OUTPUT_GATE_N_OUT,
    output logic             SPECIAL_FLAG_ONE_OUT,
    output logic             SPECIAL_FLAG_TWO_OUT,
    output logic      [8:0]  ADDR_OUT,
    input  wire logic [15:0] DQ_IN,
    output logic      [15:0] DQ_OUT,
    output logic             DQ_OE_OUT,
    // serial port
    output logic             SHIFT_CLOCK_OUT,
    output logic             SHIFT_PORT_GATE_N_OUT,
    input  wire logic [15:0] SHIFT_DATA_PINS_IN,
    output logic      [15:0] SHIFT_DATA_PINS_OUT,
    output logic             SHIFT_DATA_PINS_OE_OUT,
    input  wire logic        HALF_BOUNDARY_FLAG_IN
);

    typedef enum logic [3:0] {
        S_IDLE, S_ROW, S_RAS, S_COL, S_CAS, S_SAMPLE, S_OE_HIGH, S_DATA, S_WE, S_END, S_PRE
    } vdh_state_t;
    typedef enum logic [1:0] {SS_IDLE, SS_HIGH, SS_LOW} vdh_sstate_t;

    function automatic logic is_xfer(input vdh_pkg::vdh_op_t o);
        return (o == vdh_pkg::OP_READ_XFER) || (o == vdh_pkg::OP_MASK_XFER);
    endfunction

    // ==========================================================
    // step divider and input synchronisers
    logic [1:0]  div_cnt;
    logic        tick;
    logic [15:0] dq_m, dq_s, sio_m, sio_s;
    logic        qsf_m, qsf_s;

    assign tick = (div_cnt == 2'(vdh_pkg::STEP_CYC - 1));

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            div_cnt <= 2'h0;
        end else begin
            div_cnt <= tick ? 2'h0 : div_cnt + 2'h1;
        end
        dq_m  <= DQ_IN;
        dq_s  <= dq_m;
        sio_m <= SHIFT_DATA_PINS_IN;
        sio_s <= sio_m;
        qsf_m <= HALF_BOUNDARY_FLAG_IN;
        qsf_s <= qsf_m;
    end

    // ==========================================================
    // registers and ram cycle sequencer
    vdh_state_t            state, next_state;
    vdh_sstate_t           sstate, next_sstate;
    vdh_pkg::vdh_op_t      op, next_op;
    vdh_pkg::vdh_ram_ctl_t ctl, next_ctl;
    logic        masked, next_masked, beu, next_beu, bel, next_bel;
    logic [8:0]  row, next_row, addr, next_addr;
    logic [7:0]  col, next_col;
    logic [15:0] wdata, next_wdata, mask, next_mask, rdata, next_rdata;
    logic [15:0] dq, next_dq, swdata, next_swdata, srdata, next_srdata;
    logic        dq_oe, next_dq_oe, start, next_start, dir_out, next_dir_out;
    logic        gate, next_gate, sreq, next_sreq, sc, next_sc;
    logic [31:0] rd_word, next_rd_word;
    logic        rd_seen, next_rd_seen;
    logic        wr_op;

    assign wr_op = (op == vdh_pkg::OP_EARLY_WR) || (op == vdh_pkg::OP_DELAYED_WR) ||
                   (op == vdh_pkg::OP_RMW) || (op == vdh_pkg::OP_BLOCK_WR);

    always_comb begin
        next_state = state;    next_op = op;        next_ctl = ctl;
        next_masked = masked;  next_beu = beu;      next_bel = bel;
        next_row = row;        next_col = col;      next_addr = addr;
        next_wdata = wdata;    next_mask = mask;    next_rdata = rdata;
        next_dq = dq;          next_dq_oe = dq_oe;  next_start = start;
        next_dir_out = dir_out; next_gate = gate;   next_sreq = sreq;
        next_swdata = swdata;  next_srdata = srdata; next_sstate = sstate;
        next_sc = sc;          next_rd_seen = rd_seen;
        next_rd_word = 32'h0000_0000;
        if (WR_IN) begin
            case (ADDR_IN)
                vdh_pkg::OFF_CTRL: begin
                    if (state == S_IDLE && !start && WDATA_IN[3:0] <= 4'(vdh_pkg::OP_REFRESH_RST)) begin
                        next_op     = vdh_pkg::vdh_op_t'(WDATA_IN[vdh_pkg::CTRL_OP_LSB +: 4]);
                        next_masked = WDATA_IN[vdh_pkg::CTRL_MASKED_BIT];
                        next_beu    = WDATA_IN[vdh_pkg::CTRL_BEU_BIT];
                        next_bel    = WDATA_IN[vdh_pkg::CTRL_BEL_BIT];
                        next_start  = 1'b1;
                    end
                end
                vdh_pkg::OFF_ROW:    next_row    = WDATA_IN[8:0];
                vdh_pkg::OFF_COL:    next_col    = WDATA_IN[7:0];
                vdh_pkg::OFF_WDATA:  next_wdata  = WDATA_IN[15:0];
                vdh_pkg::OFF_MASK:   next_mask   = WDATA_IN[15:0];
                vdh_pkg::OFF_SWDATA: next_swdata = WDATA_IN[15:0];
                vdh_pkg::OFF_SCTRL: begin
                    next_gate = WDATA_IN[vdh_pkg::SCTRL_GATE_BIT];
                    // a pending request counts as busy, so a repeat is refused, not lost
                    if (WDATA_IN[vdh_pkg::SCTRL_SHIFT_BIT] && sstate == SS_IDLE && !sreq) begin
                        next_sreq = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        if (RD_IN) begin
            case (ADDR_IN)
                vdh_pkg::OFF_STATUS: next_rd_word = {28'h0, sreq || sstate != SS_IDLE, dir_out,
                                                     qsf_s, start || state != S_IDLE};
                vdh_pkg::OFF_RDATA:  next_rd_word = {16'h0, rdata};
                vdh_pkg::OFF_SRDATA: next_rd_word = {16'h0, srdata};
                vdh_pkg::OFF_ROW:    next_rd_word = {23'h0, row};
                vdh_pkg::OFF_COL:    next_rd_word = {24'h0, col};
                vdh_pkg::OFF_MASK:   next_rd_word = {16'h0, mask};
                default:             next_rd_word = 32'h0000_0000;
            endcase
        end
        if (tick) begin
            case (state)
                S_IDLE: if (start) begin
                    next_start   = 1'b0;
                    next_rd_seen = 1'b0;
                    next_state   = S_ROW;
                end
                S_ROW: begin
                    next_addr     = row;
                    next_ctl.tog_n = !is_xfer(op);
                    next_ctl.special_flag_one  = (op == vdh_pkg::OP_LOAD_MASK);
                    next_ctl.weu_n = !((masked && wr_op && beu) ||
                                       (op == vdh_pkg::OP_MASK_XFER && beu));
                    next_ctl.wel_n = !((masked && wr_op && bel) ||
                                       (op == vdh_pkg::OP_MASK_XFER && (bel || !beu)));
                    next_ctl.cas_n = (op != vdh_pkg::OP_REFRESH_RST);
                    next_dq        = mask;
                    next_dq_oe     = masked && (wr_op || op == vdh_pkg::OP_MASK_XFER);
                    next_state     = S_RAS;
                end
                S_RAS: begin
                    next_ctl.ras_n = 1'b0;
                    next_state     = (op == vdh_pkg::OP_REFRESH_RST) ? S_END : S_COL;
                end
                S_COL: begin
                    next_ctl.special_flag_one  = (op == vdh_pkg::OP_BLOCK_WR);
                    next_ctl.weu_n = 1'b1;
                    next_ctl.wel_n = 1'b1;
                    next_dq_oe     = 1'b0;
                    next_addr      = {1'b0, col};
                    if (op == vdh_pkg::OP_EARLY_WR || op == vdh_pkg::OP_BLOCK_WR ||
                        op == vdh_pkg::OP_LOAD_MASK) begin
                        next_ctl.weu_n = !(beu || op == vdh_pkg::OP_LOAD_MASK);
                        next_ctl.wel_n = !(bel || op == vdh_pkg::OP_LOAD_MASK);
                        next_dq        = (op == vdh_pkg::OP_LOAD_MASK) ? mask : wdata;
                        next_dq_oe     = 1'b1;
                    end
                    if (op == vdh_pkg::OP_READ || op == vdh_pkg::OP_RMW) begin
                        next_ctl.tog_n = 1'b0;
                    end
                    next_state = S_CAS;
                end
                S_CAS: begin
                    // flag one stays put across the column fall; it clears at cycle end
                    next_ctl.cas_n = 1'b0;
                    if (op == vdh_pkg::OP_READ || op == vdh_pkg::OP_RMW) begin
                        next_state = S_SAMPLE;
                    end else if (op == vdh_pkg::OP_DELAYED_WR || op == vdh_pkg::OP_READ_XFER) begin
                        next_state = S_OE_HIGH;
                    end else begin
                        next_state = S_END;
                    end
                end
                S_SAMPLE: begin
                    next_rdata   = dq_s;
                    next_rd_seen = 1'b1;
                    next_state   = (op == vdh_pkg::OP_RMW) ? S_OE_HIGH : S_END;
                end
                S_OE_HIGH: begin
                    next_ctl.tog_n = 1'b1;
                    // read transfer needs the gate rise while the row strobe is still low
                    next_state     = (op == vdh_pkg::OP_READ_XFER) ? S_END : S_DATA;
                end
                S_DATA: begin
                    next_dq    = wdata;
                    next_dq_oe = 1'b1;
                    next_state = S_WE;
                end
                S_WE: begin
                    next_ctl.weu_n = !beu;
                    next_ctl.wel_n = !bel;
                    next_state     = S_END;
                end
                S_END: begin
                    next_ctl   = vdh_pkg::RAM_CTL_IDLE;                    // row rise ends it
                    next_dq_oe = 1'b0;
                    if (op == vdh_pkg::OP_READ_XFER) next_dir_out = 1'b1;
                    if (op == vdh_pkg::OP_MASK_XFER) next_dir_out = 1'b0;
                    next_state = S_PRE;
                end
                S_PRE:   next_state = S_IDLE;
                default: next_state = S_IDLE;
            endcase
            // one shift takes three steps: clock high for one, then low for two
            case (sstate)
                SS_IDLE: if (sreq) begin
                    next_sreq   = 1'b0;
                    next_sc     = 1'b1;
                    next_sstate = SS_HIGH;
                end
                SS_HIGH: begin
                    if (dir_out && gate) next_srdata = sio_s;
                    next_sc     = 1'b0;
                    next_sstate = SS_LOW;
                end
                SS_LOW:  next_sstate = SS_IDLE;
                default: next_sstate = SS_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            state <= S_IDLE;  sstate <= SS_IDLE;  op <= vdh_pkg::OP_READ;
            ctl <= vdh_pkg::RAM_CTL_IDLE;
            masked <= 1'b0;   beu <= 1'b0;   bel <= 1'b0;
            row <= 9'h000;    col <= 8'h00;  addr <= 9'h000;
            wdata <= 16'h0000; mask <= 16'h0000; rdata <= 16'h0000;
            dq <= 16'h0000;   dq_oe <= 1'b0; start <= 1'b0;
            dir_out <= vdh_pkg::DIR_OUT_RST;
            gate <= 1'b0;     sreq <= 1'b0;  sc <= 1'b0;
            swdata <= 16'h0000; srdata <= 16'h0000;
            rd_word <= 32'h0000_0000; rd_seen <= 1'b0;
        end else begin
            state <= next_state;  sstate <= next_sstate;  op <= next_op;
            ctl <= next_ctl;
            masked <= next_masked; beu <= next_beu;  bel <= next_bel;
            row <= next_row;      col <= next_col;  addr <= next_addr;
            wdata <= next_wdata;  mask <= next_mask; rdata <= next_rdata;
            dq <= next_dq;        dq_oe <= next_dq_oe; start <= next_start;
            dir_out <= next_dir_out;
            gate <= next_gate;    sreq <= next_sreq; sc <= next_sc;
            swdata <= next_swdata; srdata <= next_srdata;
            rd_word <= next_rd_word; rd_seen <= next_rd_seen;
        end
    end

    // ==========================================================
    // pin drive
    assign RDATA_OUT                     = rd_word;
    assign ROW_STROBE_N_OUT              = ctl.ras_n;
    assign COL_STROBE_N_OUT              = ctl.cas_n;
    assign UPPER_BYTE_WRITE_STROBE_N_OUT = ctl.weu_n;
    assign LOWER_BYTE_WRITE_STROBE_N_OUT = ctl.wel_n;
    assign TRANSFER_OUTPUT_GATE_N_OUT    = ctl.tog_n;
    assign SPECIAL_FLAG_ONE_OUT          = ctl.special_flag_one;
    assign SPECIAL_FLAG_TWO_OUT          = 1'b0;
    assign ADDR_OUT                      = addr;
    assign DQ_OUT                        = dq;
    assign DQ_OE_OUT                     = dq_oe;
    assign SHIFT_CLOCK_OUT               = sc;
    assign SHIFT_PORT_GATE_N_OUT         = !gate;
    assign SHIFT_DATA_PINS_OUT           = swdata;
    // host drives serial pins only after a masked write transfer
    assign SHIFT_DATA_PINS_OE_OUT        = !dir_out;

    // ==========================================================
    // checks
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    sequence s_raise_gate;
        $rose(ctl.tog_n) ##3 $rose(dq_oe);
    endsequence

    AST_FLAG_TWO_LOW: assert property (SPECIAL_FLAG_TWO_OUT == 1'b0)
        else $error("special flag two driven high");
    AST_READ_STROBES_HIGH: assert property (
        (op == vdh_pkg::OP_READ && !ctl.ras_n) |-> (ctl.weu_n && ctl.wel_n))
        else $error("write strobe low during read");
    AST_FLAG_ONE_AT_ROW: assert property (
        $fell(ctl.ras_n) |-> (ctl.special_flag_one == (op == vdh_pkg::OP_LOAD_MASK)))
        else $error("flag one wrong at row strobe fall");
    AST_BLOCK_FLAG_AT_COL: assert property (
        $fell(ctl.cas_n) |-> (ctl.special_flag_one == (op == vdh_pkg::OP_BLOCK_WR)))
        else $error("flag one wrong at column strobe fall");
    AST_DELAYED_GATE_HIGH: assert property (
        (op == vdh_pkg::OP_DELAYED_WR && $fell(ctl.weu_n && ctl.wel_n))
        |-> (ctl.tog_n && dq_oe && $past(ctl.tog_n, 3)))
        else $error("delayed write strobe without gate high");
    AST_RMW_ORDER: assert property (
        (op == vdh_pkg::OP_RMW && $rose(ctl.tog_n) && !ctl.ras_n) |-> rd_seen ##0 s_raise_gate)
        else $error("rmw data driven out of order");
    AST_TICK_SPACING: assert property (tick |=> !tick [*2] ##1 tick)
        else $error("step divider period wrong");

endmodule

// ===== rtl/vdh_pkg.sv
// constants and types for the video dram host controller
// assumes a 100 MHz CLK_IN; ram pins and the shift clock are paced in whole steps, the shift gate and data follow register writes
package vdh_pkg;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_STEP_NS     = 30;
    localparam int STEP_CYC      = (T_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // register offsets (byte addresses, one word each)
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_ROW    = 8'h04;
    localparam logic [7:0] OFF_COL    = 8'h08;
    localparam logic [7:0] OFF_WDATA  = 8'h0C;
    localparam logic [7:0] OFF_MASK   = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_RDATA  = 8'h18;
    localparam logic [7:0] OFF_SCTRL  = 8'h1C;
    localparam logic [7:0] OFF_SWDATA = 8'h20;
    localparam logic [7:0] OFF_SRDATA = 8'h24;

    // ==========================================================
    // field positions
    localparam int CTRL_OP_LSB     = 0;
    localparam int CTRL_MASKED_BIT = 4;
    localparam int CTRL_BEU_BIT    = 5;
    localparam int CTRL_BEL_BIT    = 6;
    localparam int SCTRL_GATE_BIT  = 0;
    localparam int SCTRL_SHIFT_BIT = 1;

    // ==========================================================
    // commands and pin bundle
    typedef enum logic [3:0] {
        OP_READ, OP_EARLY_WR, OP_DELAYED_WR, OP_RMW, OP_BLOCK_WR,
        OP_READ_XFER, OP_MASK_XFER, OP_LOAD_MASK, OP_REFRESH_RST
    } vdh_op_t;

    typedef struct packed {
        logic ras_n;
        logic cas_n;
        logic weu_n;
        logic wel_n;
        logic tog_n;
        logic special_flag_one;
    } vdh_ram_ctl_t;

    // ==========================================================
    // values after reset
    localparam vdh_ram_ctl_t RAM_CTL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    localparam logic         DIR_OUT_RST  = 1'b1;

endpackage

// ===== testbench/dual_port_video_dram_interface_test.sv
// self-checking bench for the video dram host controller
// assumes the dram model on the pins and a strobe-port master here
`timescale 1ns/1ps
module dual_port_video_dram_interface_test;
    logic        clk, rst, wr_s, rd_s, mode_q;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, v;
    logic [15:0] dq_o, dq_m, dq_w, sd_o, sd_m, sd_w, d, mk, pm, m, lm;
    logic [8:0]  a_o, r;
    logic [7:0]  c;
    logic [1:0]  ln;
    logic        ras, cas, upper_byte_write_strobe, lower_byte_write_strobe, tog, f1, f2, dq_oe, sc, se, sd_oe, half_boundary_flag, pers;
    logic [3:0]  wop [3];
    bit   [15:0] shd [0:511][0:255];
    int          bad_count, compares;

    vdh_host u_vdh_host (.CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr_s), .RD_IN(rd_s), .RDATA_OUT(rdata), .ROW_STROBE_N_OUT(ras),
        .COL_STROBE_N_OUT(cas), .UPPER_BYTE_WRITE_STROBE_N_OUT(upper_byte_write_strobe),
        .LOWER_BYTE_WRITE_STROBE_N_OUT(lower_byte_write_strobe), .TRANSFER_OUTPUT_GATE_N_OUT(tog),
        .SPECIAL_FLAG_ONE_OUT(f1), .SPECIAL_FLAG_TWO_OUT(f2), .ADDR_OUT(a_o), .DQ_IN(dq_w),
        .DQ_OUT(dq_o), .DQ_OE_OUT(dq_oe), .SHIFT_CLOCK_OUT(sc), .SHIFT_PORT_GATE_N_OUT(se),
        .SHIFT_DATA_PINS_IN(sd_w), .SHIFT_DATA_PINS_OUT(sd_o), .SHIFT_DATA_PINS_OE_OUT(sd_oe),
        .HALF_BOUNDARY_FLAG_IN(half_boundary_flag));
    vdh_dram_model u_vdh_dram_model (.ras_n_in(ras), .cas_n_in(cas), .weu_n_in(upper_byte_write_strobe),
        .wel_n_in(lower_byte_write_strobe), .tog_n_in(tog), .special_flag_one_in(f1), .addr_in(a_o), .dq_in(dq_w),
        .dq_out(dq_m), .sc_in(sc), .se_n_in(se), .sd_in(sd_w), .sd_out(sd_m), .qsf_out(half_boundary_flag));
    assign dq_w = dq_oe ? dq_o : dq_m;
    assign sd_w = sd_oe ? sd_o : sd_m;

    // ==========================================================
    // bus cycles and checks
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dv);
        addr  <= a;
        wdata <= dv;
        wr_s  <= 1'b1;
        @(posedge clk);
        wr_s  <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] dv);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 dv = rdata;
        @(posedge clk);
    endtask
    // polls one status bit so a hung sequencer shows up as a mismatch
    task automatic wait_clear(input int b);
        logic [31:0] s;
        for (int n = 0; n < 60; n++) begin
            rd(vdh_pkg::OFF_STATUS, s);
            if (s[b] === 1'b0) return;
        end
        chk("busy", 32'h0, s);
    endtask
    task automatic run(input logic [3:0] op, input logic mw, input logic [1:0] l);
        wr(vdh_pkg::OFF_CTRL, {25'h0, l[0], l[1], mw, op});
        wait_clear(0);
    endtask
    task automatic results();
        if (bad_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ==========================================================
    // stimulus
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (40000) @(posedge clk);
        bad_count++;
        results();
    end
    initial begin
        {wr_s, rd_s, addr, wdata, bad_count, compares, pers, mode_q} = '0;
        wop = '{vdh_pkg::OP_EARLY_WR, vdh_pkg::OP_DELAYED_WR, vdh_pkg::OP_RMW};
        rst = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 chk("idle", 32'(vdh_pkg::RAM_CTL_IDLE), 32'({ras, cas, upper_byte_write_strobe, lower_byte_write_strobe, tog, f1}));
        chk("flag2", 32'h0, 32'(f2));
        void'($urandom(54));
        pm = 16'($urandom);
        @(posedge clk);
        // plain, then persistent, then fresh pin masks after the reset refresh
        for (int i = 0; i < 18; i++) begin
            if (i == 6) begin
                wr(vdh_pkg::OFF_MASK, {16'h0, pm});
                run(vdh_pkg::OP_LOAD_MASK, 1'b0, 2'b11);
                pers = 1'b1;
            end
            if (i == 12) begin
                run(vdh_pkg::OP_REFRESH_RST, 1'b0, 2'b00);
                pers = 1'b0;
            end
            r  = 9'($urandom % 512);
            c  = (i == 0) ? 8'hFF : 8'($urandom);
            d  = 16'($urandom);
            mk = 16'($urandom);
            ln = 2'(1 + $urandom % 3);
            lm = {{8{ln[1]}}, {8{ln[0]}}};
            m  = (i < 6) ? 16'hFFFF : (pers ? pm : mk);
            wr(vdh_pkg::OFF_ROW, {23'h0, r});
            wr(vdh_pkg::OFF_COL, {24'h0, c});
            wr(vdh_pkg::OFF_WDATA, {16'h0, d});
            wr(vdh_pkg::OFF_MASK, {16'h0, mk});
            run(wop[i % 3], i >= 6, ln);
            shd[r][c] = (shd[r][c] & ~(lm & m)) | (d & lm & m);
            run(vdh_pkg::OP_READ, 1'b0, 2'b00);
            rd(vdh_pkg::OFF_RDATA, v);
            chk("ram", {16'h0, shd[r][c]}, v);
        end
        // block write takes pin data as column mask only, the stored word stays
        run(vdh_pkg::OP_BLOCK_WR, 1'b0, 2'b11);
        run(vdh_pkg::OP_READ, 1'b0, 2'b00);
        rd(vdh_pkg::OFF_RDATA, v);
        chk("blk", {16'h0, shd[r][c]}, v);
        // read transfer near the half boundary, one shift with the port gated off
        wr(vdh_pkg::OFF_COL, 32'h7E);
        run(vdh_pkg::OP_READ_XFER, 1'b0, 2'b00);
        for (int k = 0; k < 4; k++) begin
            wr(vdh_pkg::OFF_SCTRL, (k == 1) ? 32'h2 : 32'h3);
            wait_clear(3);
            rd(vdh_pkg::OFF_SRDATA, v);
            if (k != 1) chk("serial", {16'h0, shd[r][8'h7E + k]}, v);
            rd(vdh_pkg::OFF_STATUS, v);
            chk("qsf", {31'h0, k >= 1}, {31'h0, v[1]});
        end
        rd(vdh_pkg::OFF_STATUS, v);
        chk("qsf_dir", 32'h3, {30'h0, v[2:1]});
        run(vdh_pkg::OP_MASK_XFER, 1'b1, 2'b00);
        rd(vdh_pkg::OFF_STATUS, v);
        chk("dir", 32'h0, {31'h0, v[2]});
        results();
    end
endmodule

// ===== testbench/vdh_dram_model.sv
// behavioural dual-port video dram for the host controller bench
// assumes the bench resolves the data pins from both enables
`timescale 1ns/1ps
module vdh_dram_model (
    // ram pins
    input  wire logic        ras_n_in,
    input  wire logic        cas_n_in,
    input  wire logic        weu_n_in,
    input  wire logic        wel_n_in,
    input  wire logic        tog_n_in,
    input  wire logic        special_flag_one_in,
    input  wire logic [8:0]  addr_in,
    input  wire logic [15:0] dq_in,
    output logic      [15:0] dq_out,
    // serial pins
    input  wire logic        sc_in,
    input  wire logic        se_n_in,
    input  wire logic [15:0] sd_in,
    output logic      [15:0] sd_out,
    output logic             qsf_out
);
    bit   [15:0] mem [0:511][0:255];
    bit   [15:0] serial_access_memory [0:255];
    bit   [15:0] hold, wm, pmask, latch, sq;
    logic [8:0]  row;
    logic [7:0]  col, ptr;
    logic        xfer, xwr, early, pers, load_mask_register_cycle, sdir, drv;

    // ==========================================================
    // ram port
    initial begin
        {row, col, ptr, xfer, xwr, early, pers, load_mask_register_cycle, qsf_out} = '0;
        sdir = 1'b1;
    end
    task automatic put(input bit [15:0] d, input bit [15:0] lanes);
        if (load_mask_register_cycle) begin
            pmask = d;
            pers  = 1'b1;
        end else
            mem[row][col] = (mem[row][col] & ~(wm & lanes)) | (d & wm & lanes);
    endtask
    always @(negedge ras_n_in) begin
        row  = addr_in;
        xfer = !tog_n_in && cas_n_in;
        xwr  = !(weu_n_in && wel_n_in);
        wm   = !xwr ? 16'hFFFF : (pers ? pmask : dq_in);
        load_mask_register_cycle  = special_flag_one_in && !xfer && !xwr;
        if (!cas_n_in && weu_n_in && !special_flag_one_in) pers = 1'b0;
        if (xfer) sdir = !xwr;
    end
    always @(negedge cas_n_in) if (!ras_n_in) begin
        col   = addr_in[7:0];
        latch = dq_in;
        early = !(weu_n_in && wel_n_in);
        if (early && !xfer && !special_flag_one_in) put(latch, {{8{!weu_n_in}}, {8{!wel_n_in}}});
    end
    // a late strobe takes the latched word in early mode, the pins otherwise
    always @(negedge weu_n_in) if (!cas_n_in && !ras_n_in && !xfer)
        put(early ? latch : dq_in, 16'hFF00);
    always @(negedge wel_n_in) if (!cas_n_in && !ras_n_in && !xfer)
        put(early ? latch : dq_in, 16'h00FF);
    always @(posedge tog_n_in) if (!ras_n_in && xfer && !xwr) begin
        for (int j = 0; j < 256; j++) serial_access_memory[j] = mem[row][j];
        ptr = col;
    end
    always @(posedge ras_n_in) if (xfer && xwr) begin
        for (int j = 0; j < 256; j++) mem[row][j] = (mem[row][j] & ~wm) | (serial_access_memory[j] & wm);
        ptr = col;
    end
    assign drv = !ras_n_in && !cas_n_in && !tog_n_in && !xfer && (weu_n_in || wel_n_in);
    always @(negedge drv) hold = mem[row][col];
    // released pins show the inverse of the last word, never a stale match
    assign dq_out = drv ? mem[row][col] : ~hold;

    // ==========================================================
    // serial port
    always @(posedge sc_in) begin
        sq      <= serial_access_memory[ptr];
        if (!sdir && !se_n_in) serial_access_memory[ptr] = sd_in;
        ptr = ptr + 8'h01;
        // flag goes high once word 127 is taken, low once word 255 is
        qsf_out <= ptr[7];
    end
    assign sd_out = (sdir && !se_n_in) ? sq : ~sq;
endmodule
